// >>> hdl/rml_link_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - The station address lies in 0..199 and frames carrying it are answered.
// - With station address zero, frames addressed to 255 are answered instead.
// - The port runs at one of eight rates from 1200 to 115200 bit/s.
// - With remote configuration enabled, bus writes to configuration registers go through.
// - With remote configuration disabled, bus writes to configuration registers are refused.
// - Registers 04h and 05h stay writable whatever the remote configuration setting.
// - A gap between frames longer than the timeout drives bus-controlled relays to alert.
// - The timeout is 0 to 99 whole seconds and zero turns gap supervision off.
// - The default reply delay answers at once with no extra wait.
// - Reply delay codes 1 to 5 hold the answer off by 10, 20, 50, 100 or 200 character times; codes 6 and 7 answer at once.
module rml_link_ctrl
    import rml_pkg::*;
#(
    parameter int CLK_FREQ   = rml_pkg::CLK_HZ,
    parameter int SEC_CYCLES = rml_pkg::SEC_CYCLES
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        enable_i,
    input  wire logic [7:0]                  station_addr_i,
    input  wire logic [2:0]                  baud_sel_i,
    input  wire logic                        remote_config_write_enable_i,
    input  wire logic [6:0]                  frame_gap_timeout_i,
    input  wire logic [2:0]                  reply_delay_select_i,
    input  wire logic [rml_pkg::RELAY_N-1:0] relay_bus_ctrl_i,
    input  wire logic [7:0]                  rx_byte_i,
    input  wire logic                        rx_valid_i,
    input  wire logic                        rx_frame_end_i,
    output logic                             bit_tick_o,
    output logic                             frame_accept_o,
    output logic                             frame_discard_o,
    output logic                             reg_wr_o,
    output logic [15:0]                      reg_wr_index_o,
    output logic [15:0]                      reg_wr_data_o,
    output logic                             wr_refused_o,
    output logic                             reply_start_o,
    output logic                             reply_pending_o,
    output logic                             addr_illegal_o,
    output logic [rml_pkg::RELAY_N-1:0]      relay_alert_o
);
    import rml_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    rml_state_t  state_q;
    rml_state_t  state_d;
    logic [2:0]  cnt_q;
    logic [7:0]  addr_byte_q;
    logic [7:0]  func_q;
    logic [15:0] idx_q;
    logic [15:0] data_q;
    logic [25:0] pre_q;
    logic [6:0]  sec_cnt_q;
    logic        gap_alert_q;
    logic        gap_alert_d;
    logic        char_tick;
    logic        delay_busy;
    logic        delay_done;
    logic        addr_legal;
    logic        addr_match;
    logic        frame_ok;
    logic        is_write;
    logic        idx_open;
    logic        wr_allowed;
    logic        reply_delay_select_std;
    logic        sec_tick;
    logic [7:0]  reply_delay_select_chars;

    ////////////////////////////////////////////////////////////////////////////
    // Address, write and delay decoding

    // Out-of-range station address never matches anything
    assign addr_legal = (station_addr_i <= ADDR_MAX);
    assign addr_match = addr_legal && (cnt_q != POS_ADDR) &&
                        ((station_addr_i == ADDR_ZERO) ? (addr_byte_q == ADDR_SUBST)
                                                       : (addr_byte_q == station_addr_i));
    assign frame_ok   = rx_frame_end_i && addr_match;
    assign is_write   = (func_q == FC_WRITE_ONE) && (cnt_q == WR_FRAME_LEN);
    assign idx_open   = (idx_q == OPEN_IDX_A) || (idx_q == OPEN_IDX_B);
    assign wr_allowed = remote_config_write_enable_i || idx_open;
    assign reply_delay_select_chars = rml_reply_delay_select_chars(reply_delay_select_i);
    assign reply_delay_select_std   = (reply_delay_select_chars == 8'h00);
    assign sec_tick   = (pre_q >= 26'(SEC_CYCLES - 1));

    // Alert once the elapsed whole seconds pass the timeout; zero disables
    assign gap_alert_d = (frame_gap_timeout_i != TIMEOUT_OFF) && !frame_ok &&
                         (sec_cnt_q > frame_gap_timeout_i);

    // Hold state waits for the reply hold-off to expire
    always_comb begin
        state_d = state_q;
        case (state_q)
            RML_ST_RECV: begin
                if (frame_ok && !reply_delay_select_std) begin
                    state_d = RML_ST_HOLD;
                end
            end
            RML_ST_HOLD: begin
                if (frame_ok) begin
                    state_d = reply_delay_select_std ? RML_ST_RECV : RML_ST_HOLD;
                end else if (delay_done) begin
                    state_d = RML_ST_RECV;
                end
            end
            default: state_d = RML_ST_RECV;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Character timing and reply hold-off

    rml_baud_gen #(
        .CLK_FREQ    (CLK_FREQ)
    ) u_baud (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .enable_i    (enable_i),
        .baud_sel_i  (baud_sel_i),
        .restart_i   (frame_ok),
        .bit_tick_o  (bit_tick_o),
        .char_tick_o (char_tick)
    );

    rml_delay u_delay (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .enable_i    (enable_i),
        .load_i      (frame_ok),
        .chars_i     (reply_delay_select_chars),
        .char_tick_i (char_tick),
        .busy_o      (delay_busy),
        .done_o      (delay_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame capture; bytes beyond the write layout are counted and clear the function code

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q       <= 3'h0;
            addr_byte_q <= 8'h00;
            func_q      <= 8'h00;
            idx_q       <= 16'h0000;
            data_q      <= 16'h0000;
        end else if (enable_i) begin
            if (rx_frame_end_i) begin
                cnt_q <= 3'h0;
            end else if (rx_valid_i) begin
                cnt_q <= (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
                case (cnt_q)
                    POS_ADDR:    addr_byte_q  <= rx_byte_i;
                    POS_FUNC:    func_q       <= rx_byte_i;
                    POS_IDX_HI:  idx_q[15:8]  <= rx_byte_i;
                    POS_IDX_LO:  idx_q[7:0]   <= rx_byte_i;
                    POS_DATA_HI: data_q[15:8] <= rx_byte_i;
                    POS_DATA_LO: data_q[7:0]  <= rx_byte_i;
                    default:     func_q       <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame outcome pulses

    // Unmatched frames only raise the discard pulse, never an answer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q         <= RML_ST_RECV;
            frame_accept_o  <= 1'b0;
            frame_discard_o <= 1'b0;
            reg_wr_o        <= 1'b0;
            wr_refused_o    <= 1'b0;
            reply_start_o   <= 1'b0;
            reply_pending_o <= 1'b0;
            addr_illegal_o  <= 1'b0;
            reg_wr_index_o  <= 16'h0000;
            reg_wr_data_o   <= 16'h0000;
        end else if (enable_i) begin
            state_q         <= state_d;
            frame_accept_o  <= frame_ok;
            frame_discard_o <= rx_frame_end_i && !addr_match;
            reg_wr_o        <= frame_ok && is_write && wr_allowed;
            wr_refused_o    <= frame_ok && is_write && !wr_allowed;
            reply_start_o   <= (frame_ok && reply_delay_select_std) ||
                               (delay_done && !frame_ok);
            reply_pending_o <= (state_d == RML_ST_HOLD);
            addr_illegal_o  <= !addr_legal;
            if (frame_ok && is_write) begin
                reg_wr_index_o <= idx_q;
                reg_wr_data_o  <= data_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame gap supervision

    // Seconds counter saturates so a long silence cannot wrap back to safe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q         <= 26'h0;
            sec_cnt_q     <= 7'h00;
            gap_alert_q   <= 1'b0;
            relay_alert_o <= '0;
        end else if (enable_i) begin
            gap_alert_q   <= gap_alert_d;
            relay_alert_o <= relay_bus_ctrl_i & {RELAY_N{gap_alert_d}};
            if (frame_ok) begin
                pre_q     <= 26'h0;
                sec_cnt_q <= 7'h00;
            end else begin
                pre_q <= sec_tick ? 26'h0 : pre_q + 26'h1;
                if (sec_tick && sec_cnt_q != SEC_CNT_SAT) begin
                    sec_cnt_q <= sec_cnt_q + 7'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    wr_gate_open_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_wr_o |-> ($past(remote_config_write_enable_i) || reg_wr_index_o == OPEN_IDX_A
                      || reg_wr_index_o == OPEN_IDX_B))
        else $error("write passed while configuration locked");

    wr_refuse_lock_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (wr_refused_o && $past(enable_i))
        |-> (!$past(remote_config_write_enable_i)
             && $past(idx_q) != OPEN_IDX_A && $past(idx_q) != OPEN_IDX_B))
        else $error("write refused without cause");

    open_idx_pass_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && frame_ok && is_write && idx_open) |=> reg_wr_o && !wr_refused_o)
        else $error("open register write not passed");

    own_addr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && rx_frame_end_i && addr_legal && station_addr_i != ADDR_ZERO
         && cnt_q != POS_ADDR && addr_byte_q == station_addr_i) |=> frame_accept_o)
        else $error("own address frame not accepted");

    subst_addr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (frame_accept_o && $past(station_addr_i) == ADDR_ZERO)
        |-> $past(addr_byte_q) == ADDR_SUBST)
        else $error("zero address accepted a non-255 frame");

    discard_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        frame_discard_o |-> !frame_accept_o && !reg_wr_o && !wr_refused_o)
        else $error("discarded frame produced activity");

    std_reply_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && frame_ok && reply_delay_select_std) |=> reply_start_o && !reply_pending_o)
        else $error("default delay did not answer at once");

    gap_alert_cause_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(gap_alert_q) |-> $past(sec_cnt_q) > $past(frame_gap_timeout_i)
                               && $past(frame_gap_timeout_i) != TIMEOUT_OFF)
        else $error("gap alert without timeout expiry");

    gap_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && frame_gap_timeout_i == TIMEOUT_OFF) |=> relay_alert_o == '0)
        else $error("alert raised with supervision off");

    // Held outputs are only judged after an enabled edge, since a frozen cycle keeps them
    pending_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && frame_ok && !reply_delay_select_std) |=> reply_pending_o && !reply_start_o)
        else $error("hold-off did not start");

    reply_end_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reply_start_o |-> !reply_pending_o)
        else $error("answer started while hold-off running");

    accept_legal_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (frame_accept_o && $past(enable_i)) |-> $past(station_addr_i) <= ADDR_MAX)
        else $error("frame accepted with illegal station address");

    discard_drop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && rx_frame_end_i && !addr_match) |=> frame_discard_o && !reg_wr_o)
        else $error("foreign frame not dropped");

    gap_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && frame_ok) |=> relay_alert_o == '0)
        else $error("alert kept after accepted frame");

    relay_mask_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(enable_i) |-> (relay_alert_o & ~$past(relay_bus_ctrl_i)) == '0)
        else $error("alert on relay not under bus control");

    bit_tick_gap_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (enable_i && bit_tick_o) |=> !bit_tick_o)
        else $error("bit tick longer than one cycle");

    write_data_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_wr_o |-> reg_wr_index_o == $past(idx_q) && reg_wr_data_o == $past(data_q))
        else $error("write payload differs from received frame");

endmodule

// >>> hdl/rml_pkg.sv
package rml_pkg;

    // Clock and time base
    localparam int CLK_HZ           = 50_000_000;
    localparam int CLK_PERIOD_NS    = 20;
    localparam int GAP_UNIT_MS      = 1000;
    localparam int SEC_CYCLES       = GAP_UNIT_MS * (1_000_000 / CLK_PERIOD_NS);

    // Station address handling
    localparam logic [7:0] ADDR_MAX   = 8'hc7;
    localparam logic [7:0] ADDR_ZERO  = 8'h00;
    localparam logic [7:0] ADDR_SUBST = 8'hff;

    // Write request layout (function, register index, value)
    localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
    localparam logic [2:0] POS_ADDR      = 3'h0;
    localparam logic [2:0] POS_FUNC      = 3'h1;
    localparam logic [2:0] POS_IDX_HI    = 3'h2;
    localparam logic [2:0] POS_IDX_LO    = 3'h3;
    localparam logic [2:0] POS_DATA_HI   = 3'h4;
    localparam logic [2:0] POS_DATA_LO   = 3'h5;
    localparam logic [2:0] WR_FRAME_LEN  = 3'h6;
    localparam logic [15:0] OPEN_IDX_A   = 16'h0004;
    localparam logic [15:0] OPEN_IDX_B   = 16'h0005;

    // Frame gap supervision
    localparam logic [6:0] TIMEOUT_OFF  = 7'h00;
    localparam logic [6:0] TIMEOUT_MAX  = 7'h63;
    localparam logic [6:0] SEC_CNT_SAT  = 7'h7f;
    localparam int         RELAY_N      = 2;

    // Character framing: start, 8 data, parity or stop, stop
    localparam logic [3:0] CHAR_BITS    = 4'hb;

    typedef enum logic [2:0] {
        RML_BAUD_1200   = 3'b000,
        RML_BAUD_2400   = 3'b001,
        RML_BAUD_4800   = 3'b010,
        RML_BAUD_9600   = 3'b011,
        RML_BAUD_19200  = 3'b100,
        RML_BAUD_38400  = 3'b101,
        RML_BAUD_57600  = 3'b110,
        RML_BAUD_115200 = 3'b111
    } rml_baud_t;

    typedef enum logic [2:0] {
        RML_REPLY_DELAY_SELECT_STD  = 3'b000,
        RML_REPLY_DELAY_SELECT_10C  = 3'b001,
        RML_REPLY_DELAY_SELECT_20C  = 3'b010,
        RML_REPLY_DELAY_SELECT_50C  = 3'b011,
        RML_REPLY_DELAY_SELECT_100C = 3'b100,
        RML_REPLY_DELAY_SELECT_200C = 3'b101
    } rml_reply_delay_select_t;

    typedef enum logic [1:0] {
        RML_ST_RECV = 2'b00,
        RML_ST_HOLD = 2'b01
    } rml_state_t;

    // Bit rate for each selection
    function automatic int rml_baud_rate(input logic [2:0] sel);
        case (sel)
            RML_BAUD_1200:   rml_baud_rate = 1200;
            RML_BAUD_2400:   rml_baud_rate = 2400;
            RML_BAUD_4800:   rml_baud_rate = 4800;
            RML_BAUD_9600:   rml_baud_rate = 9600;
            RML_BAUD_19200:  rml_baud_rate = 19200;
            RML_BAUD_38400:  rml_baud_rate = 38400;
            RML_BAUD_57600:  rml_baud_rate = 57600;
            default:         rml_baud_rate = 115200;
        endcase
    endfunction

    // Character times of hold-off for each reply delay choice
    function automatic logic [7:0] rml_reply_delay_select_chars(input logic [2:0] sel);
        case (sel)
            RML_REPLY_DELAY_SELECT_10C:  rml_reply_delay_select_chars = 8'h0a;
            RML_REPLY_DELAY_SELECT_20C:  rml_reply_delay_select_chars = 8'h14;
            RML_REPLY_DELAY_SELECT_50C:  rml_reply_delay_select_chars = 8'h32;
            RML_REPLY_DELAY_SELECT_100C: rml_reply_delay_select_chars = 8'h64;
            RML_REPLY_DELAY_SELECT_200C: rml_reply_delay_select_chars = 8'hc8;
            default:       rml_reply_delay_select_chars = 8'h00;
        endcase
    endfunction

endpackage

// >>> hdl/rml_baud_gen.sv
`timescale 1ns/1ns
module rml_baud_gen
    import rml_pkg::*;
#(
    parameter int CLK_FREQ = rml_pkg::CLK_HZ
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       enable_i,
    input  wire logic [2:0] baud_sel_i,
    input  wire logic       restart_i,
    output logic            bit_tick_o,
    output logic            char_tick_o
);
    import rml_pkg::*;

    logic [16:0] div_q;
    logic [16:0] div_last;
    logic [3:0]  bit_q;
    logic        bit_end;
    logic        char_end;

    // Divider end point follows the live rate selection
    assign div_last = 17'((CLK_FREQ / rml_baud_rate(baud_sel_i)) - 1);
    assign bit_end  = (div_q >= div_last);
    assign char_end = bit_end && (bit_q == CHAR_BITS - 4'h1);

    // Restart aligns character boundaries to the end of a frame
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q       <= 17'h0;
            bit_q       <= 4'h0;
            bit_tick_o  <= 1'b0;
            char_tick_o <= 1'b0;
        end else if (enable_i) begin
            div_q       <= (restart_i || bit_end) ? 17'h0 : div_q + 17'h1;
            bit_tick_o  <= bit_end && !restart_i;
            char_tick_o <= char_end && !restart_i;
            if (restart_i || char_end) begin
                bit_q <= 4'h0;
            end else if (bit_end) begin
                bit_q <= bit_q + 4'h1;
            end
        end
    end

endmodule

// >>> hdl/rml_delay.sv
`timescale 1ns/1ns
module rml_delay (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       enable_i,
    input  wire logic       load_i,
    input  wire logic [7:0] chars_i,
    input  wire logic       char_tick_i,
    output logic            busy_o,
    output logic            done_o
);

    logic [7:0] left_q;
    logic       last;

    assign last = busy_o && char_tick_i && (left_q == 8'h01);

    // A fresh load abandons any hold-off still running
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_q <= 8'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (enable_i) begin
            done_o <= last && !load_i;
            if (load_i) begin
                left_q <= chars_i;
                busy_o <= (chars_i != 8'h00);
            end else if (busy_o && char_tick_i) begin
                left_q <= left_q - 8'h01;
                busy_o <= !last;
            end
        end
    end

endmodule

// >>> test/rml_host_model.sv
`timescale 1ns/1ns
module rml_host_model (
    input  wire logic       clock_i,
    output logic [7:0]      rx_byte_o,
    output logic            rx_valid_o,
    output logic            rx_frame_end_o
);

    // Idle line state at time zero
    initial begin
        rx_byte_o = 8'h5a;
        rx_valid_o = 1'b0;
        rx_frame_end_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One frame: bytes with random gaps, then the end marker on its own cycle
    task automatic send(input logic [7:0] b [8], input int len);
        for (int i = 0; i < len; i++) begin
            @(negedge clock_i);
            rx_byte_o = b[i];
            rx_valid_o = 1'b1;
            @(negedge clock_i);
            rx_valid_o = 1'b0;
            rx_byte_o = ~rx_byte_o;  // Stale byte must never look reusable
            repeat ($urandom_range(2)) @(negedge clock_i);
        end
        @(negedge clock_i);
        rx_frame_end_o = 1'b1;
        @(negedge clock_i);
        rx_frame_end_o = 1'b0;
    endtask

endmodule

// >>> test/test_rml_link_ctrl.sv
`timescale 1ns/1ns
module test_rml_link_ctrl;
    import rml_pkg::*;

    // Low clock figure and short second keep the run small
    localparam int CLKF = 460800;
    localparam int SECC = 100;

    logic               clock_i;
    logic               rst_n_i;
    logic [7:0]         station_addr_i;
    logic [2:0]         baud_sel_i;
    logic               cfg_wen;
    logic [6:0]         gap_to;
    logic [2:0]         dly_sel;
    logic [RELAY_N-1:0] relay_ctrl;
    logic [RELAY_N-1:0] alert;
    logic [7:0]         rx_byte;
    logic               rx_valid, rx_end, tick, acc, disc, wr, refd, rstart, rpend, illeg;
    logic [15:0]        wr_idx, wr_dat;
    logic               clr;
    logic [4:0]         seen_q;
    logic [4:0]         e;
    int                 mismatches = 0;
    int                 n_tests = 0;
    int                 st, a, f, idx, dat, len, cnt, seed;
    int rate [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    int nch [8] = '{0, 10, 20, 50, 100, 200, 0, 0};
    int tos [2] = '{1, 99};

    rml_link_ctrl #(.CLK_FREQ(CLKF), .SEC_CYCLES(SECC)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(1'b1),
        .station_addr_i(station_addr_i), .baud_sel_i(baud_sel_i),
        .remote_config_write_enable_i(cfg_wen), .frame_gap_timeout_i(gap_to),
        .reply_delay_select_i(dly_sel), .relay_bus_ctrl_i(relay_ctrl),
        .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_frame_end_i(rx_end),
        .bit_tick_o(tick), .frame_accept_o(acc), .frame_discard_o(disc),
        .reg_wr_o(wr), .reg_wr_index_o(wr_idx), .reg_wr_data_o(wr_dat),
        .wr_refused_o(refd), .reply_start_o(rstart), .reply_pending_o(rpend),
        .addr_illegal_o(illeg), .relay_alert_o(alert));

    rml_host_model host_u (.clock_i(clock_i), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
        .rx_frame_end_o(rx_end));

    // 50 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // Pulse catcher, so the exact outcome edge does not matter
    always @(posedge clock_i) begin
        seen_q <= clr ? 5'h00 : (seen_q | {acc, disc, wr, refd, rstart});
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A wait that used its whole bound ends the run
    task automatic give_up(input int n, input int lim);
        if (n >= lim) begin
            mismatches++;
            close_out();
        end
    endtask

    // Expected {accept, discard, write, refused, reply now}
    function automatic logic [4:0] model(int a, int f, int idx, int len, int st, logic lock, int d);
        logic hit;
        logic w;
        logic ok;
        hit = len > 0 && ((st == 0) ? a == 255 : (st <= 199 && a == st));
        w = hit && f == 6 && len == 6;
        ok = w && (!lock || idx == 4 || idx == 5);
        return {hit, !hit, ok, w && !ok, hit && (d == 0 || d > 5)};
    endfunction

    task automatic frame(input int a, input int f, input int idx, input int dat, input int len);
        logic [7:0] bb [8];
        bb = '{a[7:0], f[7:0], idx[15:8], idx[7:0], dat[15:8], dat[7:0], 8'h3c, 8'hc3};
        clr = 1'b1;
        @(negedge clock_i);
        clr = 1'b0;
        host_u.send(bb, len);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        station_addr_i = 8'h01;
        baud_sel_i = 3'h7;
        cfg_wen = 1'b1;
        gap_to = 7'h00;
        dly_sel = 3'h0;
        relay_ctrl = '0;
        clr = 1'b0;
        seed = $urandom(58);
        repeat (6) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        // Addressing and write lock over a table of cases
        for (int k = 0; k < 72; k++) begin
            st = (k % 3 == 0) ? 0 : (k % 3 == 1) ? $urandom_range(199, 1) : 200;
            a = ((k / 3) % 2 == 0) ? ((st == 0) ? 255 : st)
                : ((st == 0) ? 0 : $urandom_range(255, 201));
            idx = ((k / 6) % 3 == 0) ? 4 : ((k / 6) % 3 == 1) ? 5 : $urandom_range(65535, 6);
            f = ((k / 36) % 2 == 0) ? 6 : $urandom_range(5, 1);
            len = (k % 5 == 4) ? $urandom_range(7) : 6;
            dat = $urandom_range(65535);
            station_addr_i = st[7:0];
            cfg_wen = ((k / 18) % 2 == 1);
            frame(a, f, idx, dat, len);
            repeat (3) @(negedge clock_i);
            e = model(a, f, idx, len, st, !cfg_wen, 0);
            chk(seen_q, e);
            if (e[2] || e[1]) chk({wr_idx, wr_dat}, {idx[15:0], dat[15:0]});
            chk(illeg, st > 199);
        end
        // Bit period at each rate
        station_addr_i = 8'h11;
        for (int s = 0; s < 8; s++) begin
            baud_sel_i = s[2:0];
            for (int j = 0; j < 3; j++) begin
                @(negedge clock_i);
                cnt = 1;
                while (tick !== 1'b1 && cnt < 1000) begin
                    @(negedge clock_i);
                    cnt++;
                end
                give_up(cnt, 1000);
            end
            chk(cnt, CLKF / rate[s]);
        end
        // Reply hold-off, one character is 44 cycles at the fastest rate
        for (int d = 0; d < 8; d++) begin
            dly_sel = d[2:0];
            frame(17, 3, 0, 0, 6);
            cnt = 0;
            while (rstart !== 1'b1 && cnt < 10000) begin
                if (cnt == nch[d] * 22) chk(rpend, nch[d] != 0);
                @(negedge clock_i);
                cnt++;
            end
            give_up(cnt, 10000);
            chk(cnt >= nch[d] * 44 && cnt <= nch[d] * 44 + 4, 1);
        end
        dly_sel = 3'h0;
        // Gap supervision off, long since the last frame
        relay_ctrl = 2'b11;
        repeat (600) @(negedge clock_i);
        chk(alert, 2'b00);
        // Shortest and longest timeouts
        for (int t = 0; t < 2; t++) begin
            gap_to = tos[t][6:0];
            relay_ctrl = $urandom_range(3, 1);
            frame(17, 3, 0, 0, 6);
            repeat (3) @(negedge clock_i);
            cnt = 3;
            while (alert === 2'b00 && cnt < 11000) begin
                @(negedge clock_i);
                cnt++;
            end
            give_up(cnt, 11000);
            chk(cnt >= (tos[t] + 1) * SECC - 3 && cnt <= (tos[t] + 1) * SECC + 5, 1);
            chk(alert, relay_ctrl);
            frame(17, 3, 0, 0, 6);
            repeat (3) @(negedge clock_i);
            chk(alert, 2'b00);
        end
        close_out();
    end

endmodule
